// ### rtl/mfs_dev.sv
// sensor end: filter chain and output settling qualifier
// What this block does
// - mode or rate change: accel output unsettled
// - apply new mode at end of period, power-down at next edge
// - invalid samples per rate, filters off
// - invalid samples per rate, quarter-rate filter
// - low-power/high-performance switch adds one sample, except with a filter on at cutoff 1 to 7
// - power-down entered within one microsecond
// - image path leaves user path untouched
// - gyro cascade: high-pass, low-pass, low-pass
// - gyro high-pass only when enabled
// - two-bit gyro high-pass cutoff select
// - gyro settling 45, 11, 3, 0.7 s
// - other accel cutoffs: 10 to 595 samples
`timescale 1ns/1ns
`include "mfs_params.svh"
module mfs_dev
  import mfs_pkg::*;
#(
  parameter int MS_CYCLES = `MFS_MS_NS / `MFS_CLK_NS
)(
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         odr_tick_i,
  input  wire logic [15:0]  accel_sample_i,
  input  wire logic [15:0]  gyro_sample_i,
  mfs_link_if.dev           link
);

  typedef struct packed {
    mfs_cfg_t     cur;
    mfs_cfg_t     pend;
    logic         pend_v;
    logic [9:0]   discard;
    logic         smp_stb;
    logic         smp_valid;
    logic [15:0]  acc_data;
    logic [15:0]  gyr_data;
    logic         acc_ok;
    logic         gyr_ok;
    logic         ois_on;
    logic [15:0]  hp_avg;
    logic [15:0]  lp1;
    logic [15:0]  lp2;
    logic [15:0]  gtimer;
    logic [15:0]  ms_cnt;
  } mfs_dev_st_t;

  mfs_dev_st_t st_q;
  mfs_dev_st_t st_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // first-order smoother, shift sets the corner
  function automatic logic [15:0] iir(logic [15:0] y, logic [15:0] x,
                                      logic [3:0] k);
    logic signed [16:0] d;
    d = $signed({x[15], x}) - $signed({y[15], y});
    return 16'(y + 16'(d >>> k));
  endfunction

  function automatic logic [3:0] ghp_shift(logic [1:0] c);
    logic [3:0] k;
    case (c)
      2'h0:    k = `MFS_GHP_K0;
      2'h1:    k = `MFS_GHP_K1;
      2'h2:    k = `MFS_GHP_K2;
      default: k = `MFS_GHP_K3;
    endcase
    return k;
  endfunction

  function automatic logic [15:0] gset_ms(logic [1:0] c);
    logic [15:0] t;
    case (c)
      2'h0:    t = `MFS_GSET_MS0;
      2'h1:    t = `MFS_GSET_MS1;
      2'h2:    t = `MFS_GSET_MS2;
      default: t = `MFS_GSET_MS3;
    endcase
    return t;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic         ms_tick;
    logic         apply;
    logic         acc_chg;
    logic         ghp_on;
    logic         ghp_was;
    logic [15:0]  s1;
    logic [15:0]  s2;
    mfs_cfg_t     nxt;
    ms_tick = 1'b0;
    apply   = 1'b0;
    acc_chg = 1'b0;
    ghp_on  = 1'b0;
    ghp_was = 1'b0;
    s1      = 16'h0000;
    s2      = 16'h0000;
    nxt     = st_q.cur;
    st_d    = st_q;
    st_d.smp_stb = 1'b0;

    // millisecond enable for the gyro settling timer
    if (st_q.ms_cnt == 16'(MS_CYCLES - 1))
    begin
      st_d.ms_cnt = 16'h0000;
      ms_tick     = 1'b1;
    end
    else
      st_d.ms_cnt = st_q.ms_cnt + 16'h0001;

    if (link.cfg_stb)
    begin
      st_d.pend   = link.cfg;
      st_d.pend_v = 1'b1;
    end

    // a period in progress finishes under the old setting
    if (st_q.pend_v && odr_tick_i)
      apply = 1'b1;
    // power-down does not wait for the period: next edge   
    if (st_q.pend_v && st_q.pend.mode == MFS_PD)
      apply = 1'b1;

    // accel sample leaves with the validity of its own period
    if (odr_tick_i && st_q.cur.mode != MFS_PD)
    begin
      st_d.smp_stb   = 1'b1;
      st_d.smp_valid = (st_q.discard == 10'h000);
      st_d.acc_data  = accel_sample_i;
      if (st_q.discard != 10'h000)
        st_d.discard = st_q.discard - 10'h001;
    end

    // gyro cascade runs on every sample period
    ghp_on = st_q.cur.gyro_perf & st_q.cur.gyro_hp_en;
    if (odr_tick_i)
    begin
      if (ghp_on)
      begin
        st_d.hp_avg = iir(st_q.hp_avg, gyro_sample_i,
                          ghp_shift(st_q.cur.gyro_cut));
        s1 = gyro_sample_i - st_q.hp_avg;
      end
      else
        s1 = gyro_sample_i;
      if (st_q.cur.first_lowpass_stage_en)
      begin
        st_d.lp1 = iir(st_q.lp1, s1, `MFS_LP_K);
        s2 = st_q.lp1;
      end
      else
        s2 = s1;
      st_d.lp2      = iir(st_q.lp2, s2, `MFS_LP_K);
      st_d.gyr_data = st_q.lp2;
    end

    if (st_q.gtimer != 16'h0000 && ms_tick)
      st_d.gtimer = st_q.gtimer - 16'h0001;

    if (apply)
    begin
      nxt = st_q.pend;
      // cfg received this same cycle is kept for the next period
      if (!link.cfg_stb)
        st_d.pend_v = 1'b0;
      acc_chg = nxt.mode != st_q.cur.mode || nxt.output_data_rate != st_q.cur.output_data_rate
             || nxt.second_lowpass_stage_en != st_q.cur.second_lowpass_stage_en
             || nxt.hp_path != st_q.cur.hp_path
             || nxt.cutoff != st_q.cur.cutoff;
      // image path bit is not part of the accel change test
      if (acc_chg)
        st_d.discard = mfs_discard(st_q.cur, nxt);
      ghp_was = ghp_on;
      ghp_on  = nxt.gyro_perf & nxt.gyro_hp_en;
      if (ghp_on && (!ghp_was || nxt.gyro_cut != st_q.cur.gyro_cut))
      begin
        st_d.gtimer = gset_ms(nxt.gyro_cut);
        // restart the divider: a part millisecond would end settling early
        st_d.ms_cnt = 16'h0000;
      end
      else if (!ghp_on)
        st_d.gtimer = 16'h0000;
      st_d.cur = nxt;
    end

    st_d.ois_on = st_d.cur.ois_en;
    st_d.acc_ok = st_d.cur.mode != MFS_PD
               && st_d.discard == 10'h000;
    st_d.gyr_ok = st_d.gtimer == 16'h0000;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign link.smp_stb   = st_q.smp_stb;
  assign link.smp_valid = st_q.smp_valid;
  assign link.acc_data  = st_q.acc_data;
  assign link.gyr_data  = st_q.gyr_data;
  assign link.acc_ok    = st_q.acc_ok;
  assign link.gyr_ok    = st_q.gyr_ok;
  assign link.ois_on    = st_q.ois_on;

endmodule

// ### rtl/mfs_params.svh
// constants of the motion filter settling qualifier
`ifndef MFS_PARAMS_SVH
`define MFS_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MFS_CLK_NS      50
`define MFS_MS_NS       1000000
`define MFS_PD_MAX_NS   1000
// gyro high-pass settling times in ms: 45 s, 11 s, 3 s, 0.7 s
`define MFS_GSET_MS0    16'hAFC8
`define MFS_GSET_MS1    16'h2AF8
`define MFS_GSET_MS2    16'h0BB8
`define MFS_GSET_MS3    16'h02BC

// ----------------------------------------------------------------
// samples to discard
// ----------------------------------------------------------------
`define MFS_DIS_LP_OFF  10'h001
`define MFS_DIS_LP_QTR  10'h002
`define MFS_DIS_HP_OFF  10'h002
`define MFS_DIS_HP_QTR  10'h003
`define MFS_DIS_1667    10'h003
`define MFS_DIS_3333    10'h005
`define MFS_DIS_6667    10'h00B
`define MFS_DIS_HPHP    10'h003
`define MFS_DIS_C1_LP   10'h00A
`define MFS_DIS_C1_HP   10'h00E
`define MFS_DIS_C2      10'h013
`define MFS_DIS_C3      10'h026
`define MFS_DIS_C4      10'h04B
`define MFS_DIS_C5      10'h096
`define MFS_DIS_C6      10'h128
`define MFS_DIS_C7      10'h253

// ----------------------------------------------------------------
// rate codes and filter shifts
// ----------------------------------------------------------------
`define MFS_ODR_1667    4'h8
`define MFS_ODR_3333    4'h9
`define MFS_ODR_6667    4'hA
`define MFS_GHP_K0      4'hC
`define MFS_GHP_K1      4'hA
`define MFS_GHP_K2      4'h8
`define MFS_GHP_K3      4'h6
`define MFS_LP_K        4'h1

// ----------------------------------------------------------------
// host register map and reset values
// ----------------------------------------------------------------
`define MFS_ADDR_CFG    4'h0
`define MFS_ADDR_STAT   4'h1
`define MFS_ADDR_ACC    4'h2
`define MFS_ADDR_GYR    4'h3
`define MFS_ADDR_DROP   4'h4
`define MFS_CFG_RST     18'h00000

`endif

// ### rtl/mfs_pkg.sv
// types and shared decoding of the settling qualifier
package mfs_pkg;
  `include "mfs_params.svh"

  typedef enum logic [1:0] {MFS_PD, MFS_LOWPWR, MFS_HIPERF} mfs_mode_t;

  typedef struct packed {
    mfs_mode_t    mode;
    logic [3:0]   output_data_rate;
    logic         second_lowpass_stage_en;
    logic         hp_path;
    logic [2:0]   cutoff;
    logic         ois_en;
    logic         gyro_perf;
    logic         gyro_hp_en;
    logic [1:0]   gyro_cut;
    logic         first_lowpass_stage_en;
  } mfs_cfg_t;

  // ----------------------------------------------------------------
  // invalid sample count after a configuration change
  // ----------------------------------------------------------------
  function automatic logic [9:0] mfs_discard(mfs_cfg_t prev, mfs_cfg_t nxt);
    logic [9:0] n;
    logic       filt_on;
    filt_on = nxt.second_lowpass_stage_en | nxt.hp_path;
    n = 10'h000;
    if (nxt.mode == MFS_PD)
      n = 10'h000;
    else if (filt_on && nxt.cutoff != 3'h0)
    begin
      case (nxt.cutoff)
        3'h1:    n = nxt.hp_path ? `MFS_DIS_C1_HP : `MFS_DIS_C1_LP;
        3'h2:    n = `MFS_DIS_C2;
        3'h3:    n = `MFS_DIS_C3;
        3'h4:    n = `MFS_DIS_C4;
        3'h5:    n = `MFS_DIS_C5;
        3'h6:    n = `MFS_DIS_C6;
        default: n = `MFS_DIS_C7;
      endcase
    end
    else if (prev.mode == MFS_HIPERF && nxt.mode == MFS_HIPERF
             && prev.output_data_rate != nxt.output_data_rate)
      n = `MFS_DIS_HPHP;
    else
    begin
      if (nxt.mode == MFS_LOWPWR)
        n = filt_on ? `MFS_DIS_LP_QTR : `MFS_DIS_LP_OFF;
      else if (nxt.output_data_rate == `MFS_ODR_6667)
        n = `MFS_DIS_6667;
      else if (nxt.output_data_rate == `MFS_ODR_3333)
        n = `MFS_DIS_3333;
      else if (nxt.output_data_rate == `MFS_ODR_1667)
        n = `MFS_DIS_1667;
      else
        n = filt_on ? `MFS_DIS_HP_QTR : `MFS_DIS_HP_OFF;
      if (prev.mode != MFS_PD && prev.mode != nxt.mode)
        n = n + 10'h001;
    end
    return n;
  endfunction
endpackage

// ### rtl/mfs_link_if.sv
// link between the sensor filter end and the host end
`timescale 1ns/1ns
interface mfs_link_if
  import mfs_pkg::*;
(
  input wire logic clk_i
);
  mfs_cfg_t     cfg;
  logic         cfg_stb;
  logic         smp_stb;
  logic         smp_valid;
  logic [15:0]  acc_data;
  logic [15:0]  gyr_data;
  logic         acc_ok;
  logic         gyr_ok;
  logic         ois_on;

  modport dev  (input cfg, cfg_stb,
                output smp_stb, smp_valid, acc_data, gyr_data,
                       acc_ok, gyr_ok, ois_on);
  modport host (output cfg, cfg_stb,
                input smp_stb, smp_valid, acc_data, gyr_data,
                      acc_ok, gyr_ok, ois_on);
endinterface

// ### rtl/mfs_host.sv
// host end: register port, config sender, sample keeper
`timescale 1ns/1ns
`include "mfs_params.svh"
module mfs_host
  import mfs_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [3:0]   addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [31:0]  rdata_o,
  mfs_link_if.host          link
);

  typedef struct packed {
    mfs_cfg_t     cfg;
    logic         cfg_stb;
    logic [31:0]  rdata;
    logic [15:0]  acc;
    logic [15:0]  gyr;
    logic         fresh;
    logic [15:0]  drop_cnt;
  } mfs_host_st_t;

  mfs_host_st_t st_q;
  mfs_host_st_t st_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.cfg_stb = 1'b0;
    st_d.rdata   = 32'h00000000;
    if (wr_i && addr_i == `MFS_ADDR_CFG)
    begin
      st_d.cfg     = mfs_cfg_t'(wdata_i[17:0]);
      st_d.cfg_stb = 1'b1;
    end
    if (rd_i)
    begin
      case (addr_i)
        `MFS_ADDR_CFG:  st_d.rdata = {14'h0000, st_q.cfg};
        `MFS_ADDR_STAT: st_d.rdata = {28'h0000000, st_q.fresh,
                                      link.ois_on, link.gyr_ok,
                                      link.acc_ok};
        `MFS_ADDR_ACC:  st_d.rdata = {16'h0000, st_q.acc};
        `MFS_ADDR_GYR:  st_d.rdata = {16'h0000, st_q.gyr};
        `MFS_ADDR_DROP: st_d.rdata = {16'h0000, st_q.drop_cnt};
        default:        st_d.rdata = 32'h00000000;
      endcase
      if (addr_i == `MFS_ADDR_ACC)
        st_d.fresh = 1'b0;
    end
    // unsettled samples never reach software; set beats read clear
    if (link.smp_stb)
    begin
      if (link.smp_valid)
      begin
        st_d.acc   = link.acc_data;
        st_d.fresh = 1'b1;
      end
      else
        st_d.drop_cnt = st_q.drop_cnt + 16'h0001;
      if (link.gyr_ok)
        st_d.gyr = link.gyr_data;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q     <= '0;
      st_q.cfg <= mfs_cfg_t'(`MFS_CFG_RST);
    end
    else
      st_q <= st_d;
  end

  assign rdata_o      = st_q.rdata;
  assign link.cfg     = st_q.cfg;
  assign link.cfg_stb = st_q.cfg_stb;

endmodule

// ### sim/mfs_link_asserts.sv
// concurrent checks on the link between sensor end and host end
`timescale 1ns/1ns
module mfs_link_asserts
  import mfs_pkg::*;
#(
  parameter int MS_CYCLES = 4
)(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire mfs_cfg_t    cfg,
  input wire logic        cfg_stb,
  input wire logic        smp_stb,
  input wire logic        smp_valid,
  input wire logic [15:0] acc_data,
  input wire logic [15:0] gyr_data,
  input wire logic        acc_ok,
  input wire logic        gyr_ok,
  input wire logic        ois_on
);
  // ----------------------------------------------------------------
  // helper: cycles spent with the gyro unsettled
  // ----------------------------------------------------------------
  // bound by the slowest cutoff; the bench times only the 0.7 s and 3 s codes
  localparam int GMAX = 45000 * MS_CYCLES + 16;
  logic [31:0] gyr_low_q;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      gyr_low_q <= 32'h0;
    else if (!gyr_ok)
      gyr_low_q <= gyr_low_q + 32'h1;
    else
      gyr_low_q <= 32'h0;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  pd_entry_a: assert property (cfg_stb && cfg.mode == MFS_PD
    |-> ##[1:20] !acc_ok) else $error("power-down not reached in time");
  pd_quiet_a: assert property (cfg_stb && cfg.mode == MFS_PD
    |-> ##4 (!smp_stb) [*8]) else $error("sample in power-down");
  invalid_unsettled_a: assert property (smp_stb && !smp_valid
    |-> !$past(acc_ok)) else $error("invalid sample while settled");
  settle_edge_a: assert property ($rose(acc_ok)
    |-> smp_stb || $past(smp_stb)) else $error("settle off strobe");
  acc_hold_a: assert property (!smp_stb
    |-> $stable(acc_data)) else $error("accel data moved");
  ois_iso_a: assert property ($changed(ois_on)
    |-> acc_ok == $past(acc_ok)) else $error("image path hit accel");
  gyro_hold_a: assert property ($fell(gyr_ok)
    |=> !gyr_ok [*8]) else $error("gyro settled too soon");
  gyro_bound_a: assert property (gyr_low_q <= GMAX)
    else $error("gyro never settles");
  gyro_pace_a: assert property ($changed(gyr_data)
    |-> smp_stb || !acc_ok) else $error("gyro output off sample pace");
endmodule

// ### sim/motion_filter_settling_qualifier_tb.sv
// self-checking bench for both ends of the settling qualifier link
`timescale 1ns/1ns
`include "mfs_params.svh"
module motion_filter_settling_qualifier_tb;
  import mfs_pkg::*;
  // short millisecond keeps gyro settle times inside the run
  localparam int MS = 4;
  logic        clk_i    = 1'b0;
  logic        nrst_i   = 1'b0;
  logic [3:0]  addr     = 4'h0;
  logic [31:0] wdata    = 32'h0;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic [31:0] rdata;
  logic        tick     = 1'b0;
  logic        tick_d   = 1'b0;
  logic [2:0]  tcnt     = 3'h0;
  logic [15:0] acc_s    = 16'h0;
  logic [31:0] inv_n    = 32'h0;
  logic [31:0] stb_n    = 32'h0;
  logic [15:0] last_acc = 16'h0;
  logic [15:0] exp_acc  = 16'h0;
  logic [31:0] cyc      = 32'h0;
  int          mismatches      = 0;
  int          samples_checked = 0;
  mfs_cfg_t    cur = '0;

  always #25 clk_i = ~clk_i;

  mfs_link_if mfs_link_if_i (.clk_i(clk_i));
  mfs_dev #(.MS_CYCLES(MS)) mfs_dev_i (.clk_i(clk_i), .nrst_i(nrst_i),
    .odr_tick_i(tick), .accel_sample_i(acc_s),
    .gyro_sample_i(acc_s ^ 16'h5A5A), .link(mfs_link_if_i));
  mfs_host mfs_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .link(mfs_link_if_i));
  mfs_link_asserts #(.MS_CYCLES(MS)) mfs_link_asserts_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .cfg(mfs_link_if_i.cfg),
    .cfg_stb(mfs_link_if_i.cfg_stb), .smp_stb(mfs_link_if_i.smp_stb),
    .smp_valid(mfs_link_if_i.smp_valid), .acc_data(mfs_link_if_i.acc_data),
    .gyr_data(mfs_link_if_i.gyr_data), .acc_ok(mfs_link_if_i.acc_ok),
    .gyr_ok(mfs_link_if_i.gyr_ok), .ois_on(mfs_link_if_i.ois_on));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // sample source, link monitor, hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7) && nrst_i;
    tick_d <= tick;
    if (tick)
    begin
      acc_s   <= acc_s + 16'h0101;
      exp_acc <= acc_s;
    end
    if (nrst_i && mfs_link_if_i.smp_stb === 1'b1)
    begin
      stb_n <= stb_n + 32'h1;
      chk({31'h0, tick_d}, 32'h1);
      chk({16'h0, mfs_link_if_i.acc_data}, {16'h0, exp_acc});
      if (mfs_link_if_i.smp_valid === 1'b0)
        inv_n <= inv_n + 32'h1;
      else
        last_acc <= mfs_link_if_i.acc_data;
    end
    cyc <= cyc + 32'h1;
    if (cyc == 32'h0000EA60)
    begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // register port and scenario tasks
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask

  task automatic wait_ok(input logic v, input int lim);
    int k;
    k = 0;
    while (mfs_link_if_i.acc_ok !== v && k < lim)
    begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic step(input mfs_mode_t m, input logic [3:0] o,
                      input logic [1:0] f, input logic [2:0] c,
                      input logic [9:0] n);
    logic [31:0] i0;
    logic [31:0] d;
    cur.mode = m;
    cur.output_data_rate = o;
    {cur.second_lowpass_stage_en, cur.hp_path} = f;
    cur.cutoff = c;
    i0 = inv_n;
    wr_reg(`MFS_ADDR_CFG, {14'h0, cur});
    wait_ok(1'b0, 40);
    wait_ok(1'b1, 6000);
    repeat (20) @(posedge clk_i);
    chk(inv_n - i0, {22'h0, n});
    rd_reg(`MFS_ADDR_STAT, d);
    chk({31'h0, d[0]}, 32'h1);
  endtask

  task automatic pd();
    logic [31:0] s0;
    cur.mode = MFS_PD;
    wr_reg(`MFS_ADDR_CFG, {14'h0, cur});
    repeat (20) @(posedge clk_i);
    s0 = stb_n;
    chk({31'h0, mfs_link_if_i.acc_ok}, 32'h0);
    repeat (24) @(posedge clk_i);
    chk(stb_n - s0, 32'h0);
  endtask

  task automatic gyro(input logic [1:0] c, input logic hp, input int ms);
    int k;
    cur.gyro_perf = 1'b1;
    cur.gyro_hp_en = hp;
    cur.gyro_cut = c;
    wr_reg(`MFS_ADDR_CFG, {14'h0, cur});
    k = 0;
    while (mfs_link_if_i.gyr_ok !== 1'b0 && k < 40)
    begin
      @(posedge clk_i);
      k++;
    end
    k = 0;
    while (mfs_link_if_i.gyr_ok === 1'b0 && k < 20000)
    begin
      @(posedge clk_i);
      k++;
    end
    // a few cycles of slack for the registered apply path
    chk({31'h0, k + 2 >= ms * MS && k <= ms * MS + 8}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] d;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_reg(`MFS_ADDR_STAT, d);
    chk(d & 32'h1, 32'h0);
    step(MFS_LOWPWR, 4'h1, 2'h0, 3'h0, 10'h001);
    step(MFS_LOWPWR, 4'h5, 2'h0, 3'h0, 10'h001);
    step(MFS_HIPERF, 4'h7, 2'h0, 3'h0, 10'h003);
    step(MFS_HIPERF, 4'h8, 2'h0, 3'h0, 10'h003);
    step(MFS_HIPERF, 4'hA, 2'h0, 3'h0, 10'h003);
    step(MFS_LOWPWR, 4'h4, 2'h2, 3'h0, 10'h003);
    pd();
    step(MFS_HIPERF, 4'hA, 2'h0, 3'h0, 10'h00B);
    pd();
    step(MFS_HIPERF, 4'h9, 2'h1, 3'h0, 10'h005);
    pd();
    step(MFS_HIPERF, 4'h3, 2'h2, 3'h0, 10'h003);
    step(MFS_HIPERF, 4'h3, 2'h0, 3'h0, 10'h002);
    step(MFS_LOWPWR, 4'h2, 2'h1, 3'h0, 10'h003);
    step(MFS_LOWPWR, 4'h2, 2'h2, 3'h1, 10'h00A);
    step(MFS_LOWPWR, 4'h2, 2'h1, 3'h1, 10'h00E);
    step(MFS_LOWPWR, 4'h2, 2'h2, 3'h7, 10'h253);
    step(MFS_HIPERF, 4'h6, 2'h0, 3'h0, 10'h003);
    gyro(2'h3, 1'b1, 700);
    gyro(2'h2, 1'b1, 3000);
    gyro(2'h1, 1'b0, 0);
    cur.ois_en = 1'b1;
    wr_reg(`MFS_ADDR_CFG, {14'h0, cur});
    repeat (16) @(posedge clk_i);
    chk({31'h0, mfs_link_if_i.ois_on}, 32'h1);
    chk({31'h0, mfs_link_if_i.acc_ok}, 32'h1);
    // unmapped write must leave the configuration alone
    wr_reg(4'h7, 32'h0003FFFF);
    rd_reg(`MFS_ADDR_CFG, d);
    chk(d, {14'h0, cur});
    rd_reg(4'hF, d);
    chk(d, 32'h0);
    rd_reg(`MFS_ADDR_DROP, d);
    chk(d, inv_n);
    @(posedge clk_i iff mfs_link_if_i.smp_stb === 1'b1);
    rd_reg(`MFS_ADDR_ACC, d);
    chk({16'h0, d[15:0]}, {16'h0, last_acc});
    end_of_test();
  end
endmodule
